/* shared/cvpl_consts.vh */
// cvpl_consts.vh: constants of the valid-flag and parallel-port/lock registers
// assumes inclusion by the register bank and its access gate only
`ifndef CVPL_CONSTS_VH
`define CVPL_CONSTS_VH
// register indices within configuration space
`define CVPL_IDX_VALID 8'h00
`define CVPL_IDX_PPCTL 8'h01
`define CVPL_IDX_LAST 8'h39
// power-on reset values
`define CVPL_VALID_POR 8'h28
`define CVPL_PPCTL_POR 8'h9C
// valid-flag layout
`define CVPL_VALID_BIT 7
`define CVPL_VRSV_BIT 3
`define CVPL_VALID_RO1 8'h20
`define CVPL_VALID_WMASK 8'h88
// parallel-port control layout
`define CVPL_PWR_BIT 2
`define CVPL_MODE_BIT 3
`define CVPL_LOCK_BIT 7
`define CVPL_PPCTL_RO1 8'h10
`define CVPL_PPCTL_WMASK 8'h0C
// base address floor under which decoding turns off
`define CVPL_DEC_FLOOR 16'h0100
`define CVPL_ZERO8 8'h00
`endif

/* rtl/cvpl_access_gate.v */
// cvpl_access_gate.v: qualifies configuration accesses by state, index and lock
// assumes strobes are one-cycle pulses synchronous to sys_clk
`timescale 1ns/1ps
`include "cvpl_consts.vh"
module cvpl_access_gate (
    // state and index
    input wire cfg_state,
    input wire [7:0] config_index_register,
    input wire config_space_lock,
    // raw strobes
    input wire cfg_rd,
    input wire cfg_wr,
    // qualified selects
    output wire sel_valid_rd,
    output wire sel_valid_wr,
    output wire sel_ppctl_rd,
    output wire sel_ppctl_wr,
    output wire space_open
);
    // lock low shuts every index up to the last register
    wire in_space;
    wire is_valid;
    wire is_ppctl;
    assign in_space = (config_index_register <= `CVPL_IDX_LAST);
    assign space_open = cfg_state & (config_space_lock | ~in_space);
    assign is_valid = (config_index_register == `CVPL_IDX_VALID);
    assign is_ppctl = (config_index_register == `CVPL_IDX_PPCTL);
    assign sel_valid_rd = space_open & is_valid & cfg_rd;
    assign sel_valid_wr = space_open & is_valid & cfg_wr;
    assign sel_ppctl_rd = space_open & is_ppctl & cfg_rd;
    assign sel_ppctl_wr = space_open & is_ppctl & cfg_wr;
endmodule // cvpl_access_gate

/* rtl/cvpl_regs.v */
// cvpl_regs.v: valid-flag and parallel-port power/mode/lock configuration registers
// assumes the host side delivers index, strobes and data in sys_clk, one strobe per access
`timescale 1ns/1ps
`include "cvpl_consts.vh"
module cvpl_regs (
    // clock and resets
    input wire sys_clk,
    input wire rst_b,
    input wire host_bus_rst_b,
    // configuration access
    input wire cfg_state,
    input wire [7:0] config_index_register,
    input wire cfg_rd,
    input wire cfg_wr,
    input wire [7:0] cfg_wdata,
    output wire [7:0] cfg_rdata,
    output wire cfg_rd_ack,
    output wire cfg_space_open,
    // extended mode select from the misc register
    input wire [1:0] pp_uart_misc_register,
    // parallel port base address
    input wire [15:0] pp_base_addr,
    // parallel port controls
    output wire pp_powered,
    output wire pp_printer_mode,
    output wire [1:0] pp_ext_mode,
    output wire pp_addr_decode_en,
    output wire pp_range_check,
    output wire config_space_lock
);
    // stored bits; read-only bits are not stored
    reg valid_flag_ff;
    reg vrsv_ff;
    reg pp_pwr_ff;
    reg pp_mode_ff;
    reg lock_ff;
    reg [7:0] rdata_ff;
    reg nxt_valid_flag;
    reg nxt_vrsv;
    reg nxt_pp_pwr;
    reg nxt_pp_mode;
    reg nxt_lock;
    reg [7:0] nxt_rdata;
    wire sel_valid_rd;
    wire sel_valid_wr;
    wire sel_ppctl_rd;
    wire sel_ppctl_wr;
    wire [7:0] valid_cycle_flag;
    wire [7:0] pp_power_mode_lock;
    wire [7:0] por_valid;
    wire [7:0] por_ppctl;

    // constants brought to wires so bit picks stay legal
    assign por_valid = `CVPL_VALID_POR;
    assign por_ppctl = `CVPL_PPCTL_POR;

    // access qualification shared with the rest of configuration space
    cvpl_access_gate u_gate (
        .cfg_state(cfg_state),
        .config_index_register(config_index_register),
        .config_space_lock(lock_ff),
        .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr),
        .sel_valid_rd(sel_valid_rd),
        .sel_valid_wr(sel_valid_wr),
        .sel_ppctl_rd(sel_ppctl_rd),
        .sel_ppctl_wr(sel_ppctl_wr),
        .space_open(cfg_space_open)
    );

    // read images with fixed bits merged in
    assign valid_cycle_flag = {valid_flag_ff, 3'h0, vrsv_ff, 3'h0} | `CVPL_VALID_RO1;
    assign pp_power_mode_lock = {lock_ff, 3'h0, pp_mode_ff, pp_pwr_ff, 2'h0} | `CVPL_PPCTL_RO1;

    // next-state of stored bits
    always @*
    begin
        nxt_valid_flag = valid_flag_ff;
        nxt_vrsv = vrsv_ff;
        nxt_pp_pwr = pp_pwr_ff;
        nxt_pp_mode = pp_mode_ff;
        nxt_lock = lock_ff;
        // valid flag and reserved bit 3 just store what software writes
        if (sel_valid_wr)
        begin
            nxt_valid_flag = cfg_wdata[`CVPL_VALID_BIT];
            nxt_vrsv = cfg_wdata[`CVPL_VRSV_BIT];
        end
        // pp control write; lock may only fall, never rise by software
        if (sel_ppctl_wr)
        begin
            nxt_pp_pwr = cfg_wdata[`CVPL_PWR_BIT];
            nxt_pp_mode = cfg_wdata[`CVPL_MODE_BIT];
            nxt_lock = lock_ff & cfg_wdata[`CVPL_LOCK_BIT];
        end
        // host bus reset only restores the lock, other bits keep state
        if (!host_bus_rst_b)
        begin
            nxt_lock = 1'b1;
        end
    end

    // stored bits, power-on reset loads the documented defaults
    always @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            // reset bits are picked from the named power-on images, never typed in by hand
            valid_flag_ff <= por_valid[`CVPL_VALID_BIT];
            vrsv_ff <= por_valid[`CVPL_VRSV_BIT];
            pp_pwr_ff <= por_ppctl[`CVPL_PWR_BIT];
            pp_mode_ff <= por_ppctl[`CVPL_MODE_BIT];
            lock_ff <= por_ppctl[`CVPL_LOCK_BIT];
        end
        else
        begin
            valid_flag_ff <= nxt_valid_flag;
            vrsv_ff <= nxt_vrsv;
            pp_pwr_ff <= nxt_pp_pwr;
            pp_mode_ff <= nxt_pp_mode;
            lock_ff <= nxt_lock;
        end
    end

    // read data select; a blocked read returns zero so nothing leaks
    always @*
    begin
        nxt_rdata = `CVPL_ZERO8;
        if (sel_valid_rd)
        begin
            nxt_rdata = valid_cycle_flag;
        end
        else if (sel_ppctl_rd)
        begin
            nxt_rdata = pp_power_mode_lock;
        end
    end

    // registered read data, one cycle after the strobe
    always @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            rdata_ff <= `CVPL_ZERO8;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ack flop so read data and ack line up
    reg rd_ack_ff;
    always @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            rd_ack_ff <= 1'b0;
        end
        else
        begin
            rd_ack_ff <= sel_valid_rd | sel_ppctl_rd;
        end
    end

    assign cfg_rdata = rdata_ff;
    assign cfg_rd_ack = rd_ack_ff;

    // port controls; power bit gates the port but never its decoder
    assign pp_powered = pp_pwr_ff;
    assign pp_printer_mode = pp_mode_ff;
    // extended select only matters when printer mode is off
    assign pp_ext_mode = pp_mode_ff ? 2'h0 : pp_uart_misc_register;
    assign pp_addr_decode_en = (pp_base_addr >= `CVPL_DEC_FLOOR);
    assign pp_range_check = pp_addr_decode_en;
    assign config_space_lock = lock_ff;
endmodule // cvpl_regs

/* verif/cvpl_regs_asserts.sv */
// cvpl_regs_asserts.sv: port checks of the config registers
// assumes a bind onto cvpl_regs, one clock
`timescale 1ns/1ps
module cvpl_regs_asserts (
    // clock and resets
    input wire sys_clk,
    input wire rst_b,
    input wire host_bus_rst_b,
    // access and status
    input wire cfg_state,
    input wire [7:0] config_index_register,
    input wire cfg_rd,
    input wire [7:0] cfg_rdata,
    input wire cfg_rd_ack,
    input wire [15:0] pp_base_addr,
    input wire pp_addr_decode_en,
    input wire pp_range_check,
    input wire config_space_lock
);
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // a read the gate must take
    wire ok_rd = cfg_rd && cfg_state && config_index_register < 8'h02 && config_space_lock;
    property p_ack; ok_rd |=> cfg_rd_ack; endproperty
    a_ack: assert property (p_ack) else $error("read not acked");
    property p_nak; cfg_rd && !ok_rd |=> !cfg_rd_ack && cfg_rdata == 8'h00; endproperty
    a_nak: assert property (p_nak) else $error("refused read answered");
    property p_vb; cfg_rd_ack && $past(config_index_register) == 8'h00 |-> (cfg_rdata & 8'h77) == 8'h20; endproperty
    a_vb: assert property (p_vb) else $error("valid flag fixed bits");
    property p_pb; cfg_rd_ack && $past(config_index_register) == 8'h01 |-> (cfg_rdata & 8'h73) == 8'h10; endproperty
    a_pb: assert property (p_pb) else $error("pp control fixed bits");
    // reset of the whole bank also raises lock, so it excuses a rise
    property p_lk; $rose(config_space_lock) |-> !$past(host_bus_rst_b) || !$past(rst_b); endproperty
    a_lk: assert property (p_lk) else $error("lock set by software");
    property p_hr; !host_bus_rst_b |=> config_space_lock; endproperty
    a_hr: assert property (p_hr) else $error("hard reset kept lock low");
    property p_dec; {pp_addr_decode_en, pp_range_check} == {2{pp_base_addr >= 16'h0100}}; endproperty
    a_dec: assert property (p_dec) else $error("decode enable wrong");
    property p_lka; cfg_rd_ack |-> $past(config_space_lock); endproperty
    a_lka: assert property (p_lka) else $error("read while locked");
    c_rd: cover property (ok_rd);
    c_lk: cover property ($fell(config_space_lock));
    c_hr: cover property (!host_bus_rst_b && !config_space_lock);
endmodule // cvpl_regs_asserts

/* verif/test_cvpl_regs.sv */
// test_cvpl_regs.sv: directed bench for the config registers
// assumes cvpl_regs and its checker are compiled first
`timescale 1ns/1ps
module test_cvpl_regs;
    reg sys_clk = 0, rst_b = 0, host_bus_rst_b = 1, cfg_state = 1, cfg_rd = 0, cfg_wr = 0;
    reg [7:0] config_index_register = 8'h00, cfg_wdata = 8'h00;
    reg [1:0] pp_uart_misc_register = 2'h0;
    reg [15:0] pp_base_addr = 16'h0378;
    wire [7:0] cfg_rdata;
    wire [1:0] pp_ext_mode;
    wire cfg_rd_ack, cfg_space_open, pp_powered, pp_printer_mode, pp_addr_decode_en, pp_range_check;
    wire config_space_lock;
    integer miscompares = 0, n_checks = 0, i;
    // controls packed so one compare covers them all
    wire [7:0] ctl = {pp_range_check, cfg_space_open, pp_ext_mode, pp_powered,
        pp_printer_mode, pp_addr_decode_en, config_space_lock};
    cvpl_regs cvpl_regs_i (.*);
    initial forever #12.5 sys_clk = ~sys_clk;
    task chk(input [7:0] seen, input [7:0] exp);
    begin
        n_checks = n_checks + 1;
        miscompares = miscompares + (seen !== exp);
        if (seen !== exp)
            $display("unexpected at %0t: %h expected %h", $time, seen, exp);
    end
    endtask
    // an idle edge first, so a strobe is never raised where it fell
    task wr(input [7:0] idx, input [7:0] d);
    begin
        @(posedge sys_clk) #1 config_index_register = idx;
        cfg_wdata = d;
        cfg_wr = 1;
        @(posedge sys_clk) #1 cfg_wr = 0;
    end
    endtask
    task rd(input [7:0] idx, input [7:0] exp, input ack);
    begin
        @(posedge sys_clk) #1 config_index_register = idx;
        cfg_rd = 1;
        @(posedge sys_clk) #1 cfg_rd = 0;
        chk(cfg_rdata, exp);
        chk({7'h00, cfg_rd_ack}, {7'h00, ack});
    end
    endtask
    task end_sim;
    begin
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    task t_por;
    begin
        rd(8'h00, 8'h28, 1);
        rd(8'h01, 8'h9C, 1);
        chk(ctl, 8'hCF);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'hA8, 1);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h20, 1);
    end
    endtask
    task t_mode;
    begin
        wr(8'h01, 8'hF3);
        rd(8'h01, 8'h90, 1);
        for (i = 0; i < 4; i = i + 1)
        begin
            pp_uart_misc_register = i[1:0];
            pp_base_addr = i[0] ? 16'h0100 : 16'h00FF;
            #1 chk(ctl, {i[0], 1'b1, i[1:0], 2'h0, i[0], 1'b1});
        end
    end
    endtask
    task t_lock;
    begin
        cfg_state = 0;
        rd(8'h00, 8'h00, 0);
        cfg_state = 1;
        rd(8'h02, 8'h00, 0);
        wr(8'h01, 8'h04);
        rd(8'h01, 8'h00, 0);
        wr(8'h01, 8'h8C);
        chk(ctl, 8'hBA);
        config_index_register = 8'h3A;
        #1 chk({7'h00, cfg_space_open}, 8'h01);
        host_bus_rst_b = 0;
        @(posedge sys_clk) #1 host_bus_rst_b = 1;
        rd(8'h01, 8'h94, 1);
        rst_b = 0;
        @(posedge sys_clk) #1 rst_b = 1;
        rd(8'h00, 8'h28, 1);
    end
    endtask
    initial
    begin
        #20000 miscompares = miscompares + 1;
        end_sim;
    end
    initial
    begin
        repeat (10) @(posedge sys_clk);
        #1 rst_b = 1;
        t_por;
        t_mode;
        t_lock;
        end_sim;
    end
endmodule // test_cvpl_regs
bind cvpl_regs cvpl_regs_asserts cvpl_regs_asserts_i (.*);
